// *** rtl/pfm_pkg.sv ***
// Constants for the pin function multiplexer
// Functional notes
// R1 - Wake context survives D3-to-D0 segment reset; the code keeps it only while pme_enable is set
// R2 - Power-up clears selectors, legacy pin functions
// R3 - Serial data pin input before supply good
// R4 - After supply good serial data may drive
// R5 - Undefined selector codes give legacy function
// R6 - Low bits 1:0 select interrupt A/LED or general_pin_one
// R7 - Low bits 3:2 select serial irq/LED or general_pin_two
// R8 - Low bits 5:4 select speaker or general_pin_three
// R9 - Low bits 7:6 select LED/suspend, general_pin_four, event
// R10 - Event output also via high bits 1:0
// R11 - Config bit 2 adds PCI interrupts to stream
// R12 - Config bit 8 locks both selector registers
// R13 - Config bit 9 disables read prefetch
// R14 - Config bit 10 stops automatic card reset in D3
// R15 - High code 00 keeps interrupt B/ring; 7:2 reserved
// R16 - Locked writes ignored, reads return held values
// R17 - Legacy drive stops when new selector applies
package pfm_pkg;

	// Register byte addresses (memory space for selectors, config space for misc)
	localparam logic [11:0] PFM_PIN_SEL_LOW_OFS  = 12'h914;
	localparam logic [11:0] PFM_PIN_SEL_HIGH_OFS = 12'h915;
	localparam logic [11:0] PFM_CFG_MISC_OFS     = 12'h098;

	// Reset values
	localparam logic [7:0]  PFM_PIN_SEL_LOW_RST  = 8'h00;
	localparam logic [1:0]  PFM_PIN_SEL_HIGH_RST = 2'h0;
	localparam logic [31:0] PFM_CFG_MISC_RST     = 32'h0000_0000;

	// Misc configuration bit positions
	localparam int PFM_CFG_SERIRQ_PCI_BIT  = 2;
	localparam int PFM_CFG_LOCK_BIT        = 8;
	localparam int PFM_CFG_NO_PREFETCH_BIT = 9;
	localparam int PFM_CFG_NO_D3_RESET_BIT = 10;

	// Selector codes
	localparam logic [1:0] PFM_CODE_LEGACY = 2'h0;
	localparam logic [1:0] PFM_CODE_GPIO   = 2'h1;
	localparam logic [1:0] PFM_CODE_PME    = 2'h2;

	// Multiplexed pins: 0 int A/LED, 1 serial irq/LED B, 2 speaker, 3 LED/suspend, 4 int B/ring
	localparam int         PFM_NUM_PINS = 5;
	localparam logic [4:0] PFM_GPIO_OK  = 5'h0f;
	localparam logic [4:0] PFM_PME_OK   = 5'h18;

	// Power states
	localparam logic [1:0] PFM_PSTATE_D0 = 2'h0;
	localparam logic [1:0] PFM_PSTATE_D3 = 2'h3;

endpackage

// *** rtl/pfm_pin_mux.sv ***
// Pin function multiplexer with selector, lock and wake context logic
`timescale 1ns/1ps
module pfm_pin_mux (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Register access port
	input  wire logic        reg_cfg,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [11:0] reg_addr,
	input  wire logic [3:0]  reg_be,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	output logic             reg_rvalid,
	// Power management state
	input  wire logic [1:0]  pm_state,
	input  wire logic        pme_enable,
	input  wire logic        seg_reset,
	input  wire logic        pme_req,
	// Function sources per multiplexed pin
	input  wire logic [4:0]  legacy_out,
	input  wire logic [4:0]  legacy_oe,
	input  wire logic [4:0]  gpio_out,
	input  wire logic [4:0]  gpio_oe,
	// Multiplexed pins
	input  wire logic [4:0]  pin_in,
	output logic      [4:0]  pin_out,
	output logic      [4:0]  pin_oe,
	output logic      [4:0]  legacy_in,
	output logic      [4:0]  gpio_in,
	// Serial power-switch data pin
	input  wire logic        supply_good,
	input  wire logic        power_switch_serial_data_src,
	input  wire logic        power_switch_serial_data_oe_req,
	input  wire logic        power_switch_serial_data_in,
	output logic             power_switch_serial_data_out,
	output logic             power_switch_serial_data_oe,
	output logic             psw_reset_level,
	// Configuration effects
	input  wire logic        card_reset_req,
	output logic             serirq_include_pci,
	output logic             prefetch_disable,
	output logic             card_auto_reset
);

	// Selector and configuration state
	logic [7:0]  pin_sel_low_reg;     // Wake context, four pin fields
	logic [7:0]  pin_sel_low_next;
	logic [1:0]  pin_sel_high_reg;    // Wake context, bits 7:2 not stored
	logic [1:0]  pin_sel_high_next;
	logic [31:0] cfg_misc_reg;
	logic [31:0] cfg_misc_next;

	// Decode of the access
	wire        sel_hit   = !reg_cfg && (reg_addr[11:2] == pfm_pkg::PFM_PIN_SEL_LOW_OFS[11:2]);
	wire        cfg_hit   = reg_cfg && (reg_addr[11:2] == pfm_pkg::PFM_CFG_MISC_OFS[11:2]);
	wire        lock      = cfg_misc_reg[pfm_pkg::PFM_CFG_LOCK_BIT];
	wire        low_wr    = reg_wr && sel_hit && reg_be[pfm_pkg::PFM_PIN_SEL_LOW_OFS[1:0]]
	                        && !lock; // [R12] [R16]
	wire        high_wr   = reg_wr && sel_hit && reg_be[pfm_pkg::PFM_PIN_SEL_HIGH_OFS[1:0]]
	                        && !lock; // [R12] [R16]
	// Wake context is kept when waking from D3 with wake enabled
	wire        keep_ctx  = pme_enable && (pm_state == pfm_pkg::PFM_PSTATE_D3); // [R1]
	wire        clear_ctx = seg_reset && !keep_ctx; // [R1]
	wire [9:0]  sel_vec   = {pin_sel_high_next, pin_sel_low_next};
	wire [7:0]  high_rd   = {6'h00, pin_sel_high_reg}; // [R15]
	wire [31:0] sel_rd    = {16'h0000, high_rd, pin_sel_low_reg}; // [R16]
	wire [31:0] rdata_nx  = sel_hit ? sel_rd : (cfg_hit ? cfg_misc_reg : 32'h0000_0000);

	// Next selector values; clearing by segment reset beats a write
	always_comb begin
		pin_sel_low_next  = pin_sel_low_reg;
		pin_sel_high_next = pin_sel_high_reg;
		if (clear_ctx) begin
			pin_sel_low_next  = pfm_pkg::PFM_PIN_SEL_LOW_RST;
			pin_sel_high_next = pfm_pkg::PFM_PIN_SEL_HIGH_RST;
		end else begin
			if (low_wr) begin
				pin_sel_low_next = reg_wdata[7:0];
			end
			if (high_wr) begin
				pin_sel_high_next = reg_wdata[9:8];
			end
		end
	end

	// Next config value, per byte lane; not part of the wake context
	always_comb begin
		cfg_misc_next = cfg_misc_reg;
		if (seg_reset) begin
			cfg_misc_next = pfm_pkg::PFM_CFG_MISC_RST;
		end else if (reg_wr && cfg_hit) begin
			for (int b = 0; b < 4; b++) begin
				if (reg_be[b]) begin
					cfg_misc_next[8*b +: 8] = reg_wdata[8*b +: 8];
				end
			end
		end
	end

	// Register state; power-up reset clears everything
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pin_sel_low_reg  <= pfm_pkg::PFM_PIN_SEL_LOW_RST; // [R2]
			pin_sel_high_reg <= pfm_pkg::PFM_PIN_SEL_HIGH_RST; // [R2]
			cfg_misc_reg     <= pfm_pkg::PFM_CFG_MISC_RST;
		end else begin
			pin_sel_low_reg  <= pin_sel_low_next; // [R1]
			pin_sel_high_reg <= pin_sel_high_next;
			cfg_misc_reg     <= cfg_misc_next;
		end
	end

	// Read answer, one cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata  <= 32'h0000_0000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rdata  <= reg_rd ? rdata_nx : 32'h0000_0000;
			reg_rvalid <= reg_rd;
		end
	end

	// Per-pin function selection, decoded from the next selector so the
	// pin changes in the same cycle the new selector becomes visible
	genvar i;
	generate
		for (i = 0; i < pfm_pkg::PFM_NUM_PINS; i++) begin : g_pin
			wire [1:0] code   = sel_vec[2*i +: 2];
			// Undefined codes, and codes a pin lacks, fall back to legacy
			wire       is_gpio = (code == pfm_pkg::PFM_CODE_GPIO) && pfm_pkg::PFM_GPIO_OK[i]; // [R5]
			wire       is_pme  = (code == pfm_pkg::PFM_CODE_PME) && pfm_pkg::PFM_PME_OK[i]; // [R9] [R10]
			// Event output is open drain, active low
			wire       out_nx  = is_pme ? 1'b0 : (is_gpio ? gpio_out[i] : legacy_out[i]);
			wire       oe_nx   = is_pme ? pme_req : (is_gpio ? gpio_oe[i] : legacy_oe[i]);
			always_ff @(posedge sys_clk) begin
				if (rst) begin
					pin_out[i]   <= 1'b1;
					pin_oe[i]    <= 1'b0;
					legacy_in[i] <= 1'b1;
					gpio_in[i]   <= 1'b0;
				end else begin
					pin_out[i]   <= out_nx; // [R6] [R7] [R8] [R9] [R15] [R17]
					pin_oe[i]    <= oe_nx; // [R17]
					// Inputs are only seen by the function that owns the pin
					legacy_in[i] <= (is_gpio || is_pme) ? 1'b1 : pin_in[i];
					gpio_in[i]   <= is_gpio ? pin_in[i] : 1'b0;
				end
			end
		end
	endgenerate

	// Serial power-switch data pin; stays an input until supply good
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			power_switch_serial_data_out <= 1'b0;
			power_switch_serial_data_oe  <= 1'b0;
			psw_reset_level              <= 1'b0;
		end else begin
			power_switch_serial_data_out <= power_switch_serial_data_src;
			power_switch_serial_data_oe  <= supply_good && power_switch_serial_data_oe_req; // [R3] [R4]
			// External reset level is only meaningful while the pin is an input
			if (!supply_good) begin
				psw_reset_level <= !power_switch_serial_data_in; // [R3]
			end
		end
	end

	// Configuration effects
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			serirq_include_pci <= 1'b0;
			prefetch_disable   <= 1'b0;
			card_auto_reset    <= 1'b0;
		end else begin
			serirq_include_pci <= cfg_misc_reg[pfm_pkg::PFM_CFG_SERIRQ_PCI_BIT]; // [R11]
			prefetch_disable   <= cfg_misc_reg[pfm_pkg::PFM_CFG_NO_PREFETCH_BIT]; // [R13]
			card_auto_reset    <= card_reset_req && !(cfg_misc_reg[pfm_pkg::PFM_CFG_NO_D3_RESET_BIT]
			                      && (pm_state == pfm_pkg::PFM_PSTATE_D3)); // [R14]
		end
	end

	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_low_write;
		reg_wr && sel_hit && reg_be[0] && !seg_reset;
	endsequence

	sequence s_wake_reset;
		seg_reset && pme_enable && (pm_state == pfm_pkg::PFM_PSTATE_D3);
	endsequence

	property p_wake_keep;
		s_wake_reset |=> $stable(pin_sel_low_reg) && $stable(pin_sel_high_reg);
	endproperty
	a_wake_keep: assert property (p_wake_keep) else $error("wake context lost"); // [R1]

	property p_ctx_clear;
		seg_reset && !pme_enable |=> pin_sel_low_reg == 8'h00 && pin_sel_high_reg == 2'h0;
	endproperty
	a_ctx_clear: assert property (p_ctx_clear) else $error("selectors not cleared"); // [R1]

	property p_powerup;
		@(posedge sys_clk) disable iff (1'b0) rst |=> pin_sel_low_reg == 8'h00 && pin_oe == 5'h00;
	endproperty
	a_powerup: assert property (p_powerup) else $error("power-up state wrong"); // [R2]

	property p_power_switch_serial_data_input;
		!supply_good |=> !power_switch_serial_data_oe;
	endproperty
	a_power_switch_serial_data_input: assert property (p_power_switch_serial_data_input) else $error("data pin driven early"); // [R3]

	property p_power_switch_serial_data_output;
		supply_good && power_switch_serial_data_oe_req |=> power_switch_serial_data_oe
		                               && power_switch_serial_data_out == $past(power_switch_serial_data_src);
	endproperty
	a_power_switch_serial_data_output: assert property (p_power_switch_serial_data_output) else $error("data pin not driven"); // [R4]

	property p_bad_code;
		pin_sel_low_reg[1:0] == 2'h3 |-> pin_oe[0] == $past(legacy_oe[0])
		                                 && pin_out[0] == $past(legacy_out[0]);
	endproperty
	a_bad_code: assert property (p_bad_code) else $error("bad code not legacy"); // [R5]

	property p_gpio_three;
		pin_sel_low_reg[5:4] == 2'h1 |-> pin_oe[2] == $past(gpio_oe[2])
		                                 && pin_out[2] == $past(gpio_out[2]);
	endproperty
	a_gpio_three: assert property (p_gpio_three) else $error("gpio three not routed"); // [R8]

	property p_pme_pin;
		s_low_write ##0 (!lock && reg_wdata[7:6] == 2'h2) ##0 pme_req
		|=> !pin_out[3] && pin_oe[3];
	endproperty
	a_pme_pin: assert property (p_pme_pin) else $error("event not on pin"); // [R9] [R17]

	property p_pme_high;
		pin_sel_high_reg == 2'h2 |-> pin_oe[4] == $past(pme_req) && !pin_out[4];
	endproperty
	a_pme_high: assert property (p_pme_high) else $error("event not on high pin"); // [R10]

	property p_lock;
		s_low_write ##0 lock |=> $stable(pin_sel_low_reg) ##1 $stable(pin_sel_low_reg) || !lock;
	endproperty
	a_lock: assert property (p_lock) else $error("locked write took effect"); // [R12] [R16]

	property p_serirq;
		cfg_misc_reg[pfm_pkg::PFM_CFG_SERIRQ_PCI_BIT] |=> serirq_include_pci;
	endproperty
	a_serirq: assert property (p_serirq) else $error("serial stream bit ignored"); // [R11]

	property p_prefetch;
		cfg_misc_reg[pfm_pkg::PFM_CFG_NO_PREFETCH_BIT] |=> prefetch_disable;
	endproperty
	a_prefetch: assert property (p_prefetch) else $error("prefetch not disabled"); // [R13]

	property p_no_d3_reset;
		cfg_misc_reg[pfm_pkg::PFM_CFG_NO_D3_RESET_BIT] && pm_state == pfm_pkg::PFM_PSTATE_D3
		|=> !card_auto_reset;
	endproperty
	a_no_d3_reset: assert property (p_no_d3_reset) else $error("card reset in D3"); // [R14]

endmodule

// *** verification/pfm_board_model.sv ***
// Board model: pull-ups on the mux pins and the supply-good switch on serial data
`timescale 1ns/1ps
module pfm_board_model (
	// Device pin drive
	input  wire logic [4:0] pin_out,
	input  wire logic [4:0] pin_oe,
	input  wire logic       sd_out,
	input  wire logic       sd_oe,
	// Board state
	input  wire logic       supply_good,
	input  wire logic       bus_rst_lvl,
	// Resolved wire levels
	output logic      [4:0] pin_lvl,
	output logic            sd_lvl
);
	// Released pins float high through board resistors
	assign pin_lvl = (pin_oe & pin_out) | ~pin_oe;
	// Switch joins bus reset to the data pin until supply is good
	assign sd_lvl = !supply_good ? bus_rst_lvl : (sd_oe ? sd_out : 1'b1);
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the pin function multiplexer
`timescale 1ns/1ps
module tb;
	logic        sys_clk = 0, rst = 1;              // Clock and reset
	logic        reg_cfg = 0, reg_wr = 0, reg_rd = 0; // Register strobes
	logic [11:0] reg_addr = 0;
	logic [3:0]  reg_be = 0;
	logic [31:0] reg_wdata = 0, reg_rdata;
	logic        reg_rvalid;
	logic [1:0]  pm_state = 0;                      // Power state inputs
	logic        pme_enable = 0, seg_reset = 0, pme_req = 0;
	logic [4:0]  legacy_out = 0, legacy_oe = 0, gpio_out = 0, gpio_oe = 0;
	logic [4:0]  pin_in, pin_out, pin_oe, legacy_in, gpio_in;
	logic        supply_good = 0, power_switch_serial_data_src = 0, power_switch_serial_data_oe_req = 1, bus_rst_lvl = 0;
	logic        sd_in, sd_out, sd_oe, psw_reset_level, card_reset_req = 0;
	logic        serirq_include_pci, prefetch_disable, card_auto_reset;
	logic [31:0] exp_q[$];                          // Expected read data
	int          err_total = 0, total_checks = 0;
	logic [7:0]  low = 0, high = 0;                 // Selector values last written

	always #2.5 sys_clk = ~sys_clk;

	pfm_pin_mux i_dut (.sys_clk, .rst, .reg_cfg, .reg_wr, .reg_rd, .reg_addr, .reg_be,
		.reg_wdata, .reg_rdata, .reg_rvalid, .pm_state, .pme_enable, .seg_reset, .pme_req,
		.legacy_out, .legacy_oe, .gpio_out, .gpio_oe, .pin_in, .pin_out, .pin_oe,
		.legacy_in, .gpio_in, .supply_good, .power_switch_serial_data_src, .power_switch_serial_data_oe_req,
		.power_switch_serial_data_in(sd_in), .power_switch_serial_data_out(sd_out),
		.power_switch_serial_data_oe(sd_oe), .psw_reset_level, .card_reset_req,
		.serirq_include_pci, .prefetch_disable, .card_auto_reset);

	pfm_board_model i_board (.pin_out, .pin_oe, .sd_out, .sd_oe, .supply_good,
		.bus_rst_lvl, .pin_lvl(pin_in), .sd_lvl(sd_in));

	// Compare one value and count it
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic end_sim();
		if (err_total == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// One strobe cycle; a read notes its expected data for the monitor
	task automatic acc(input logic cfg, wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_cfg <= cfg;
		reg_addr <= a;
		reg_be <= 4'hf;
		reg_wdata <= d;
		reg_wr <= wr;
		reg_rd <= !wr;
		if (!wr)
			exp_q.push_back(d);
		@(posedge sys_clk);
		reg_wr <= 0;
		reg_rd <= 0;
	endtask

	// Expected drive per pin: out, oe, gpio flag, non-legacy flag
	function automatic logic [19:0] pins(input logic [7:0] lo, input logic [1:0] hi);
		logic [1:0]  c;
		logic [9:0]  v;
		logic [19:0] r;
		r = '0;
		v = {hi, lo};                                   // All five fields, high pin last
		for (int i = 0; i < 5; i++) begin
			c = v[2*i +: 2];
			if (c == pfm_pkg::PFM_CODE_GPIO && pfm_pkg::PFM_GPIO_OK[i]) begin
				r[i] = gpio_out[i];
				r[5+i] = gpio_oe[i];
				r[10+i] = 1'b1;
				r[15+i] = 1'b1;
			end else if (c == pfm_pkg::PFM_CODE_PME && pfm_pkg::PFM_PME_OK[i]) begin
				r[5+i] = pme_req;                   // Open drain, drives low only
				r[15+i] = 1'b1;
			end else begin
				r[i] = legacy_out[i];               // Default, undefined or pin-unsupported code
				r[5+i] = legacy_oe[i];
			end
		end
		return r;
	endfunction

	// Pin outputs against the selectors; out only matters while driven
	task automatic pin_chk();
		logic [19:0] e;
		logic [4:0]  lvl;
		e = pins(low, high[1:0]);
		lvl = (e[9:5] & e[4:0]) | ~e[9:5];
		check(32'(pin_oe), 32'(e[9:5]));
		check(32'(pin_out & e[9:5]), 32'(e[4:0] & e[9:5]));
		check(32'(gpio_in), 32'(lvl & e[14:10]));
		check(32'(legacy_in), 32'(lvl | e[19:15]));
	endtask

	// Read results are matched oldest first
	always @(negedge sys_clk)
		if (reg_rvalid === 1'b1)
			check(reg_rdata, exp_q.pop_front());

	// Hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#20000;
		err_total++;
		end_sim();
	end

	initial begin
		void'($urandom(66));
		repeat (16) @(posedge sys_clk);
		rst <= 0;
		acc(0, 0, 12'h914, 32'h0);
		acc(1, 0, 12'h098, 32'h0);
		acc(0, 0, 12'h100, 32'h0);
		#1 pin_chk();
		check(32'(sd_oe), 32'h0);
		check(32'(psw_reset_level), 32'h1);
		// Random selectors, undefined codes and reserved bits included
		repeat (24) begin
			@(posedge sys_clk);
			low = 8'($urandom);
			high = 8'($urandom);
			legacy_out <= 5'($urandom);
			legacy_oe <= 5'($urandom);
			gpio_out <= 5'($urandom);
			gpio_oe <= 5'($urandom);
			pme_req <= 1'($urandom);
			acc(0, 1, 12'h914, {16'h0, high, low});
			acc(0, 0, 12'h914, {22'h0, high[1:0], low});
			repeat (2) @(posedge sys_clk);
			#1 pin_chk();
		end
		// Lock, prefetch off, stream inclusion, no card reset in D3
		acc(1, 1, 12'h098, 32'h0000_0704);
		acc(1, 0, 12'h098, 32'h0000_0704);
		acc(0, 1, 12'h914, {16'h0, ~high, ~low});
		acc(0, 0, 12'h914, {22'h0, high[1:0], low});
		card_reset_req <= 1;
		pm_state <= pfm_pkg::PFM_PSTATE_D3;
		repeat (3) @(posedge sys_clk);
		#1 check(32'(serirq_include_pci), 32'h1);
		check(32'(prefetch_disable), 32'h1);
		check(32'(card_auto_reset), 32'h0);
		@(posedge sys_clk);
		pm_state <= pfm_pkg::PFM_PSTATE_D0;
		repeat (3) @(posedge sys_clk);
		#1 check(32'(card_auto_reset), 32'h1);
		// Wake context kept over a segment reset from D3 when enabled, cleared by one from D0 when not
		acc(1, 1, 12'h098, 32'h0);
		acc(0, 1, 12'h914, 32'h0000_0280);
		@(posedge sys_clk);
		pme_enable <= 1;
		pm_state <= pfm_pkg::PFM_PSTATE_D3;
		seg_reset <= 1;
		@(posedge sys_clk);
		seg_reset <= 0;
		pm_state <= pfm_pkg::PFM_PSTATE_D0;
		acc(0, 0, 12'h914, 32'h0000_0280);
		@(posedge sys_clk);
		pme_enable <= 0;
		seg_reset <= 1;
		@(posedge sys_clk);
		seg_reset <= 0;
		acc(0, 0, 12'h914, 32'h0);
		// Reset level sensed on the data pin while supply is not good
		@(posedge sys_clk);
		bus_rst_lvl <= 1;
		repeat (3) @(posedge sys_clk);
		#1 check(32'(psw_reset_level), 32'h0);
		check(32'(sd_oe), 32'h0);
		check(32'(serirq_include_pci), 32'h0);
		check(32'(prefetch_disable), 32'h0);
		@(posedge sys_clk);
		bus_rst_lvl <= 0;
		repeat (3) @(posedge sys_clk);
		// Serial data pin may drive once supply is good
		@(posedge sys_clk);
		supply_good <= 1;
		power_switch_serial_data_src <= 1;
		repeat (3) @(posedge sys_clk);
		#1 check(32'(sd_oe), 32'h1);
		check(32'(sd_out), 32'h1);
		check(32'(psw_reset_level), 32'h1);
		repeat (3) @(posedge sys_clk);
		check(32'(exp_q.size()), 32'h0);
		end_sim();
	end
endmodule
